// *** hw/epc_cfg.svh ***
`ifndef EPC_CFG_SVH
`define EPC_CFG_SVH

// bus and pin widths
`define EPC_ADDR_W        22
`define EPC_DATA_W        16
`define EPC_CS_W          8
`define EPC_GEN_W         8

// chip select used by the address/data multiplexed space
`define EPC_MUX_CS_IDX    6

// data phase length of a multiplexed access, in core_clk cycles
`define EPC_DATA_CYCLES   2'h2

// idle level of the pin function select: 0 is the reset-time function
`define EPC_FUNC_RESET    1'b0
`define EPC_FUNC_NORMAL   1'b1

`endif

// *** hw/epc_pkg.sv ***
package epc_pkg;

    // target of an access
    typedef enum logic [1:0] {
        EPC_SP_ROM = 2'b00,
        EPC_SP_RAM = 2'b01,
        EPC_SP_PER = 2'b10,
        EPC_SP_MUX = 2'b11
    } epc_space_t;

    // byte lanes of a 16-bit access
    typedef enum logic [1:0] {
        EPC_BY_UPPER = 2'b00,
        EPC_BY_LOWER = 2'b01,
        EPC_BY_WORD  = 2'b10
    } epc_byte_t;

    // sequencer states
    typedef enum logic [2:0] {
        EPC_ST_IDLE   = 3'b000,
        EPC_ST_ONCHIP = 3'b001,
        EPC_ST_ADDR   = 3'b010,
        EPC_ST_DATA   = 3'b011,
        EPC_ST_STBY   = 3'b100
    } epc_state_t;

endpackage

// *** hw/epc_strobe_dec.sv ***
`timescale 1ns/10ps
`default_nettype none

// strobe and lane decode for one access cycle of the multiplexed space
module epc_strobe_dec
    import epc_pkg::*;
(
    // phase of the access
    input  wire logic      in_addr,
    input  wire logic      in_data,
    // access attributes
    input  wire logic      is_write,
    input  wire logic      wide,
    input  wire epc_byte_t bsel,
    input  wire logic      byte_sel_scheme,
    input  wire logic      addr0,
    // pin levels
    output logic           mux_cs_n,
    output logic           rd_n,
    output logic           upper_store_n,
    output logic           lower_store_n,
    output logic           a0_hbs,
    output logic           ah,
    // lane control: drive enable and address-not-data select
    output logic           hi_drive,
    output logic           hi_addr,
    output logic           lo_drive,
    output logic           lo_addr
);
    wire logic active  = in_addr | in_data;
    wire logic hi_data = wide & (bsel != EPC_BY_LOWER);
    wire logic lo_data = ~wide | (bsel != EPC_BY_UPPER);

    // chip select spans the whole access
    assign mux_cs_n = ~active;
    assign ah       = in_addr;
    assign rd_n     = ~(in_data & ~is_write);
    // shared pin: store strobe or low byte select, only in 16-bit space
    assign upper_store_n = ~(wide & (byte_sel_scheme
                             ? (active & (bsel != EPC_BY_UPPER))
                             : (in_data & is_write & hi_data)));
    // plain 8-bit writes use the lower store strobe alone
    assign lower_store_n = ~(in_data & is_write &
                             (byte_sel_scheme | ~wide | lo_data));
    // high byte select low for upper and word, high for lower
    assign a0_hbs = wide ? (bsel == EPC_BY_LOWER) : addr0;

    // in 16-bit space a lane carrying no data keeps showing address through the data phase; in 8-bit space the upper lane floats
    assign hi_drive = wide & (in_addr | (in_data & (~hi_data | is_write)));
    assign hi_addr  = in_addr | ~hi_data;
    assign lo_drive = in_addr | (in_data & (~lo_data | is_write));
    assign lo_addr  = in_addr | ~lo_data;
endmodule

`default_nettype wire

// *** hw/epc_pin_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "epc_cfg.svh"

// Notes on behaviour
// - In standby, state-holding inputs float and state-holding outputs keep their last level.
// - With the standby output float bit set, state-holding outputs float in standby instead.
// - The wait input pull-up is on when its enable bit is 1 outside standby, and off when it is 0 or in standby.
// - Multiplexed pins carry a different function during reset than in normal operation.
// - On-chip accesses keep all chip selects and active-low strobes high and float bus and parity lines.
// - Mux-space accesses pull its select low, keep DRAM strobes high, read and 8-bit write low.
// - The address hold strobe is asserted only in the address phase, though in 16-bit space a lane carrying no data keeps the address through the data phase.
// - The upper store strobe or low byte select pin serves 16-bit space accesses only.
module epc_pin_ctrl
    import epc_pkg::*;
(
    // clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    sys_rst,
    // control bits
    input  wire logic                    standby_output_float,
    input  wire logic                    wait_pullup_enable,
    input  wire logic                    standby_req,
    // access request from the core
    input  wire logic                    acc_start,
    input  wire epc_space_t              acc_space,
    input  wire logic                    acc_write,
    input  wire logic                    acc_wide,
    input  wire epc_byte_t               acc_bsel,
    input  wire logic                    acc_byte_sel_scheme,
    input  wire logic [`EPC_ADDR_W-1:0]  acc_addr,
    input  wire logic [`EPC_DATA_W-1:0]  acc_wdata,
    output logic                         acc_ready,
    output logic                         acc_done,
    output logic [`EPC_DATA_W-1:0]       acc_rdata,
    // bus control pins, active low unless named otherwise
    output logic [`EPC_CS_W-1:0]         cs_n,
    output logic                         ras_n,
    output logic                         column_strobe_upper_n,
    output logic                         column_strobe_lower_n,
    output logic                         read_strobe_n,
    output logic                         upper_store_strobe_n,
    output logic                         lower_store_strobe_n,
    output logic                         a0_high_byte_select,
    output logic                         address_hold_strobe,
    output logic [`EPC_ADDR_W-1:1]       addr_out,
    output logic                         bus_ctrl_oe_n,
    output logic                         wait_pullup_on,
    // muxed address/data lines and parity lines
    input  wire logic [`EPC_DATA_W-1:0]  muxed_bus_lines_in,
    output logic [`EPC_DATA_W-1:0]       muxed_bus_lines_out,
    output logic [`EPC_DATA_W-1:0]       muxed_bus_lines_oe_n,
    output logic                         parity_line_upper_out,
    output logic                         parity_line_upper_oe_n,
    output logic                         parity_line_lower_out,
    output logic                         parity_line_lower_oe_n,
    // state-holding general pins
    input  wire logic [`EPC_GEN_W-1:0]   gen_core_out,
    input  wire logic [`EPC_GEN_W-1:0]   gen_core_dir,
    output logic [`EPC_GEN_W-1:0]        gen_core_in,
    input  wire logic [`EPC_GEN_W-1:0]   gen_pin_in,
    output logic [`EPC_GEN_W-1:0]        gen_pin_out,
    output logic [`EPC_GEN_W-1:0]        gen_pin_oe_n,
    output logic                         gen_in_buf_en,
    output logic                         mux_pin_func
);
    localparam int HALF = `EPC_DATA_W / 2;

    epc_state_t                  state_reg, state_next;
    logic [1:0]                  cnt_reg, cnt_next;
    logic                        write_reg, wide_reg, bsc_reg;
    epc_byte_t                   bsel_reg;
    logic [`EPC_ADDR_W-1:0]      addr_reg;
    logic [`EPC_DATA_W-1:0]      wdata_reg;
    logic [`EPC_CS_W-1:0]        cs_n_reg;
    logic                        rd_n_reg, wrh_n_reg, wrl_n_reg, a0_reg, ah_reg;
    logic [`EPC_ADDR_W-1:1]      addr_out_reg;
    logic [`EPC_DATA_W-1:0]      bus_out_reg, bus_oe_n_reg, rdata_reg;
    logic                        done_reg, ready_reg, stby_reg, pull_reg, func_reg;
    logic [`EPC_GEN_W-1:0]       gen_out_reg, gen_oe_n_reg, gen_in_reg;

    // attribute values seen by the next cycle
    wire logic                   take      = (state_reg == EPC_ST_IDLE) & acc_start & ~standby_req;
    wire logic                   write_nx  = take ? acc_write : write_reg;
    wire logic                   wide_nx   = take ? acc_wide : wide_reg;
    wire logic                   bsc_nx    = take ? acc_byte_sel_scheme : bsc_reg;
    wire epc_byte_t              bsel_nx   = take ? acc_bsel : bsel_reg;
    wire logic [`EPC_ADDR_W-1:0] addr_nx   = take ? acc_addr : addr_reg;
    wire logic [`EPC_DATA_W-1:0] wdata_nx  = take ? acc_wdata : wdata_reg;
    wire logic                   last_data = (state_reg == EPC_ST_DATA) &
                                             (cnt_reg == `EPC_DATA_CYCLES - 2'h1);
    wire logic                   stby_nx   = (state_next == EPC_ST_STBY);

    // sequencer: standby only entered between accesses
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            EPC_ST_IDLE: begin
                if (standby_req) begin
                    state_next = EPC_ST_STBY;
                end else if (take) begin
                    state_next = (acc_space == EPC_SP_MUX) ? EPC_ST_ADDR : EPC_ST_ONCHIP;
                end
            end
            EPC_ST_ONCHIP: begin
                state_next = EPC_ST_IDLE;
            end
            EPC_ST_ADDR: begin
                state_next = EPC_ST_DATA;
                cnt_next   = 2'h0;
            end
            EPC_ST_DATA: begin
                cnt_next = cnt_reg + 2'h1;
                if (last_data) begin
                    state_next = EPC_ST_IDLE;
                end
            end
            EPC_ST_STBY: begin
                if (!standby_req) begin
                    state_next = EPC_ST_IDLE;
                end
            end
            default: begin
                state_next = EPC_ST_IDLE;
            end
        endcase
    end

    // pin levels for the coming cycle
    logic mux_cs_n, rd_n, wrh_n, wrl_n, a0_hbs, ah;
    logic hi_drive, hi_addr, lo_drive, lo_addr;

    epc_strobe_dec u_dec (
        .in_addr         (state_next == EPC_ST_ADDR),
        .in_data         (state_next == EPC_ST_DATA),
        .is_write        (write_nx),
        .wide            (wide_nx),
        .bsel            (bsel_nx),
        .byte_sel_scheme (bsc_nx),
        .addr0           (addr_nx[0]),
        .mux_cs_n        (mux_cs_n),
        .rd_n            (rd_n),
        .upper_store_n   (wrh_n),
        .lower_store_n   (wrl_n),
        .a0_hbs          (a0_hbs),
        .ah              (ah),
        .hi_drive        (hi_drive),
        .hi_addr         (hi_addr),
        .lo_drive        (lo_drive),
        .lo_addr         (lo_addr)
    );

    // every select other than the mux one stays high; on-chip cycles leave all high
    wire logic [`EPC_CS_W-1:0] cs_n_nx = ~({{(`EPC_CS_W-1){1'b0}}, ~mux_cs_n}
                                           << `EPC_MUX_CS_IDX);
    // lanes float on on-chip cycles since no decoder phase is active there
    wire logic [`EPC_DATA_W-1:0] bus_nx = {hi_addr ? addr_nx[15:8] : wdata_nx[15:8],
                                           lo_addr ? addr_nx[7:0]  : wdata_nx[7:0]};
    wire logic [`EPC_DATA_W-1:0] oe_nx  = ~{{HALF{hi_drive}}, {HALF{lo_drive}}};

    // standby: outputs hold their level, or float when asked
    wire logic [`EPC_GEN_W-1:0] gen_oe_nx  = stby_nx
                                             ? (standby_output_float ? {`EPC_GEN_W{1'b1}}
                                                                     : gen_oe_n_reg)
                                             : ~gen_core_dir;
    wire logic [`EPC_GEN_W-1:0] gen_out_nx = stby_nx ? gen_out_reg : gen_core_out;

    // sequencer and attribute registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= EPC_ST_IDLE;
            cnt_reg   <= 2'h0;
            write_reg <= 1'b0;
            wide_reg  <= 1'b0;
            bsc_reg   <= 1'b0;
            bsel_reg  <= EPC_BY_WORD;
            addr_reg  <= {`EPC_ADDR_W{1'b0}};
            wdata_reg <= {`EPC_DATA_W{1'b0}};
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            write_reg <= write_nx;
            wide_reg  <= wide_nx;
            bsc_reg   <= bsc_nx;
            bsel_reg  <= bsel_nx;
            addr_reg  <= addr_nx;
            wdata_reg <= wdata_nx;
        end
    end

    // bus pin registers; DRAM strobes never leave high here
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cs_n_reg     <= {`EPC_CS_W{1'b1}};
            rd_n_reg     <= 1'b1;
            wrh_n_reg    <= 1'b1;
            wrl_n_reg    <= 1'b1;
            a0_reg       <= 1'b0;
            ah_reg       <= 1'b0;
            addr_out_reg <= {(`EPC_ADDR_W-1){1'b0}};
            bus_out_reg  <= {`EPC_DATA_W{1'b0}};
            bus_oe_n_reg <= {`EPC_DATA_W{1'b1}};
        end else begin
            cs_n_reg     <= cs_n_nx;
            rd_n_reg     <= rd_n;
            wrh_n_reg    <= wrh_n;
            wrl_n_reg    <= wrl_n;
            a0_reg       <= a0_hbs;
            ah_reg       <= ah;
            addr_out_reg <= addr_nx[`EPC_ADDR_W-1:1];
            bus_out_reg  <= bus_nx;
            bus_oe_n_reg <= stby_nx ? {`EPC_DATA_W{1'b1}} : oe_nx;
        end
    end

    // handshake, read data and power-down state
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata_reg <= {`EPC_DATA_W{1'b0}};
            done_reg  <= 1'b0;
            ready_reg <= 1'b0;
            stby_reg  <= 1'b0;
            pull_reg  <= 1'b0;
            func_reg  <= `EPC_FUNC_RESET;
        end else begin
            if (last_data && !write_reg) begin
                rdata_reg <= muxed_bus_lines_in;
            end
            done_reg  <= last_data | (state_reg == EPC_ST_ONCHIP);
            ready_reg <= (state_next == EPC_ST_IDLE) & ~standby_req;
            stby_reg  <= stby_nx;
            // wait input floats in standby, so its pull-up drops too
            pull_reg  <= wait_pullup_enable & ~stby_nx;
            func_reg  <= `EPC_FUNC_NORMAL;
        end
    end

    // general pins: reset leaves them as inputs
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            gen_out_reg  <= {`EPC_GEN_W{1'b0}};
            gen_oe_n_reg <= {`EPC_GEN_W{1'b1}};
            gen_in_reg   <= {`EPC_GEN_W{1'b0}};
        end else begin
            gen_out_reg  <= gen_out_nx;
            gen_oe_n_reg <= gen_oe_nx;
            if (!stby_reg) begin
                gen_in_reg <= gen_pin_in;
            end
        end
    end

    // port drive straight from registers, except parity and DRAM strobe pins held at constants
    assign acc_ready              = ready_reg;
    assign acc_done               = done_reg;
    assign acc_rdata              = rdata_reg;
    assign cs_n                   = cs_n_reg;
    assign ras_n                  = func_reg | 1'b1;
    assign column_strobe_upper_n  = func_reg | 1'b1;
    assign column_strobe_lower_n  = func_reg | 1'b1;
    assign read_strobe_n          = rd_n_reg;
    assign upper_store_strobe_n   = wrh_n_reg;
    assign lower_store_strobe_n   = wrl_n_reg;
    assign a0_high_byte_select    = a0_reg;
    assign address_hold_strobe    = ah_reg;
    assign addr_out               = addr_out_reg;
    assign bus_ctrl_oe_n          = stby_reg;
    assign wait_pullup_on         = pull_reg;
    assign muxed_bus_lines_out    = bus_out_reg;
    assign muxed_bus_lines_oe_n   = bus_oe_n_reg;
    // parity is not generated for on-chip or mux space, lines stay floated
    assign parity_line_upper_out  = 1'b0;
    assign parity_line_upper_oe_n = 1'b1;
    assign parity_line_lower_out  = 1'b0;
    assign parity_line_lower_oe_n = 1'b1;
    assign gen_core_in            = gen_in_reg;
    assign gen_pin_out            = gen_out_reg;
    assign gen_pin_oe_n           = gen_oe_n_reg;
    assign gen_in_buf_en          = ~stby_reg;
    assign mux_pin_func           = func_reg;
endmodule

`default_nettype wire

// *** test/epc_mux_periph.sv ***
`timescale 1ns/10ps
`default_nettype none

// peripheral on the multiplexed space: latches address, answers reads
module epc_mux_periph (
    // clock
    input  wire logic        core_clk,
    // control pins from the device
    input  wire logic        sel_n,
    input  wire logic        ah,
    input  wire logic        rd_n,
    // muxed lines as driven by the device
    input  wire logic [15:0] bus_out,
    input  wire logic [15:0] bus_oe_n,
    // resolved line level and what the peripheral captured
    output logic      [15:0] bus_level,
    output logic      [15:0] wr_seen,
    output logic      [15:0] addr_seen
);
    logic [15:0] last_reg = 16'h0;

    // address taken on the hold strobe; write data is captured with no
    // reliance on the upper store pin, which 8-bit space does not carry
    always @(posedge core_clk) begin
        if (!sel_n && ah) addr_seen <= bus_out;
        if (!sel_n && !ah && rd_n) wr_seen <= bus_level;
        last_reg <= bus_level;
    end

    // floated lines toggle so a stale value never looks valid
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (!bus_oe_n[i]) bus_level[i] = bus_out[i];
            else if (!sel_n && !rd_n) bus_level[i] = ~addr_seen[i];
            else bus_level[i] = ~last_reg[i];
        end
    end
endmodule

`default_nettype wire

// *** test/epc_pin_ctrl_properties.sv ***
`timescale 1ns/10ps
`default_nettype none

// pin-level checks of the bus pin controller, seen at its ports
module epc_pin_ctrl_properties
    import epc_pkg::*;
(
    // clock and reset
    input wire logic        core_clk,
    input wire logic        sys_rst,
    // control bits and request
    input wire logic        standby_output_float,
    input wire logic        wait_pullup_enable,
    input wire logic        acc_start,
    input wire logic        acc_ready,
    input wire epc_space_t  acc_space,
    input wire logic        acc_write,
    input wire logic        acc_wide,
    input wire epc_byte_t   acc_bsel,
    // bus pins
    input wire logic [7:0]  cs_n,
    input wire logic        ras_n,
    input wire logic        column_strobe_upper_n,
    input wire logic        column_strobe_lower_n,
    input wire logic        read_strobe_n,
    input wire logic        a0_high_byte_select,
    input wire logic        address_hold_strobe,
    input wire logic [15:0] muxed_bus_lines_oe_n,
    input wire logic        parity_line_upper_oe_n,
    input wire logic        parity_line_lower_oe_n,
    input wire logic        bus_ctrl_oe_n,
    input wire logic        wait_pullup_on,
    // general pins
    input wire logic [7:0]  gen_pin_out,
    input wire logic [7:0]  gen_pin_oe_n,
    input wire logic        gen_in_buf_en,
    input wire logic        mux_pin_func
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    // request taken this cycle, split by target
    wire logic take = acc_start && acc_ready;
    wire logic mux_take = take && acc_space == EPC_SP_MUX;

    a_onchip_quiet: assert property (
        take && !mux_take |=> cs_n == 8'hff && read_strobe_n && muxed_bus_lines_oe_n == 16'hffff)
        else $error("on-chip access drove bus pins");
    a_dram_parity_idle: assert property (
        ras_n && column_strobe_upper_n && column_strobe_lower_n
        && parity_line_upper_oe_n && parity_line_lower_oe_n) else $error("dram or parity pin active");
    a_mux_select: assert property (
        mux_take |=> (cs_n == 8'hbf) [*3] ##1 cs_n == 8'hff) else $error("mux select wrong");
    a_addr_hold: assert property (
        mux_take |=> address_hold_strobe ##1 !address_hold_strobe [*3])
        else $error("address hold strobe wrong");
    a_read_strobe: assert property (
        mux_take && !acc_write |=> read_strobe_n ##1 !read_strobe_n [*2] ##1 read_strobe_n)
        else $error("read strobe wrong");
    a_high_byte_sel: assert property (
        mux_take && acc_wide |=> a0_high_byte_select == ($past(acc_bsel) == EPC_BY_LOWER))
        else $error("high byte select wrong");
    a_pullup_follow: assert property (
        !$past(sys_rst) && gen_in_buf_en && $past(gen_in_buf_en) && $past(gen_in_buf_en, 2)
        |-> wait_pullup_on == $past(wait_pullup_enable)) else $error("wait pull-up wrong");
    a_standby_hold: assert property (
        !gen_in_buf_en && !$past(gen_in_buf_en) |-> $stable(gen_pin_out) && bus_ctrl_oe_n
        && (standby_output_float ? gen_pin_oe_n == 8'hff : $stable(gen_pin_oe_n)))
        else $error("standby pin state wrong");
    a_func_release: assert property (
        $fell(sys_rst) |-> !mux_pin_func ##1 mux_pin_func) else $error("pin function wrong");
endmodule

`default_nettype wire

// *** test/epc_tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module tb;
    import epc_pkg::*;
    typedef struct packed {
        epc_space_t sp;
        logic wr, wide;
        epc_byte_t bs;
        logic sch;
        logic [21:0] a;
        logic [15:0] d;
    } epc_row_t;

    logic core_clk = 1'b0, sys_rst = 1'b1, standby_output_float = 1'b0, standby_req = 1'b0;
    logic wait_pullup_enable = 1'b0, acc_start = 1'b0, acc_write = 1'b0, acc_wide = 1'b0;
    logic acc_byte_sel_scheme = 1'b0;
    epc_space_t acc_space = EPC_SP_ROM;
    epc_byte_t acc_bsel = EPC_BY_WORD;
    logic [21:0] acc_addr = 22'h0;
    logic [21:1] addr_out;
    logic [15:0] acc_wdata = 16'h0, acc_rdata, muxed_bus_lines_in, muxed_bus_lines_out;
    logic [15:0] muxed_bus_lines_oe_n, wr_seen, addr_seen;
    logic [7:0] gen_core_out = 8'h0, gen_core_dir = 8'h0, gen_pin_in = 8'h0;
    logic [7:0] gen_core_in, gen_pin_out, gen_pin_oe_n, cs_n;
    logic acc_ready, acc_done, ras_n, column_strobe_upper_n, column_strobe_lower_n;
    logic read_strobe_n, upper_store_strobe_n, lower_store_strobe_n, a0_high_byte_select;
    logic address_hold_strobe, bus_ctrl_oe_n, wait_pullup_on, gen_in_buf_en, mux_pin_func;
    logic parity_line_upper_out, parity_line_upper_oe_n;
    logic parity_line_lower_out, parity_line_lower_oe_n;
    int fails = 0, n_tests = 0;

    // ordinary accesses: target, write, wide, lanes, scheme, address, data
    epc_row_t rows [12] = '{
        '{EPC_SP_ROM, 1'b0, 1'b0, EPC_BY_WORD, 1'b0, 22'h01234, 16'h0000},
        '{EPC_SP_PER, 1'b1, 1'b0, EPC_BY_WORD, 1'b0, 22'h3fffe, 16'h1234},
        '{EPC_SP_RAM, 1'b1, 1'b1, EPC_BY_WORD, 1'b1, 22'h05678, 16'h9abc},
        '{EPC_SP_MUX, 1'b0, 1'b0, EPC_BY_WORD, 1'b0, 22'h2a5a4, 16'h0000},
        '{EPC_SP_MUX, 1'b1, 1'b0, EPC_BY_WORD, 1'b1, 22'h1c3d1, 16'h00c3},
        '{EPC_SP_MUX, 1'b1, 1'b1, EPC_BY_UPPER, 1'b0, 22'h30f0e, 16'h7e00},
        '{EPC_SP_MUX, 1'b1, 1'b1, EPC_BY_LOWER, 1'b0, 22'h0e1f1, 16'h0081},
        '{EPC_SP_MUX, 1'b1, 1'b1, EPC_BY_WORD, 1'b0, 22'h12468, 16'hbeef},
        '{EPC_SP_MUX, 1'b0, 1'b1, EPC_BY_WORD, 1'b0, 22'h3579a, 16'h0000},
        '{EPC_SP_MUX, 1'b1, 1'b1, EPC_BY_UPPER, 1'b1, 22'h2468a, 16'h5500},
        '{EPC_SP_MUX, 1'b0, 1'b1, EPC_BY_LOWER, 1'b1, 22'h13579, 16'h0000},
        '{EPC_SP_MUX, 1'b1, 1'b1, EPC_BY_WORD, 1'b1, 22'h0f0f0, 16'hc0de}};

    epc_pin_ctrl DUT (.*);
    epc_mux_periph u_periph (.core_clk(core_clk), .sel_n(cs_n[6]), .ah(address_hold_strobe),
        .rd_n(read_strobe_n), .bus_out(muxed_bus_lines_out), .bus_oe_n(muxed_bus_lines_oe_n),
        .bus_level(muxed_bus_lines_in), .wr_seen(wr_seen), .addr_seen(addr_seen));

    // 50 MHz core clock
    initial begin
        forever #10 core_clk = ~core_clk;
    end

    task automatic results();
        $display("fails %0d n_tests %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step();
        @(posedge core_clk);
        #1;
    endtask

    // bounded wait; a hang ends the run with a mismatch
    task automatic wait_ready();
        int k = 0;
        while (acc_ready !== 1'b1 && k < 20) begin
            step();
            k++;
        end
        if (acc_ready !== 1'b1) begin
            fails++;
            $display("MISMATCH %0t ready never came", $time);
            results();
        end
    endtask

    // one access, pins checked phase by phase from the row alone
    task automatic run(input epc_row_t r);
        logic [15:0] m, a1;
        logic h, us1, us2, ls;
        m = !r.wide ? 16'h00ff : r.bs == EPC_BY_UPPER ? 16'hff00
            : r.bs == EPC_BY_LOWER ? 16'h00ff : 16'hffff;
        a1 = r.wide ? 16'h0000 : 16'hff00;
        h = r.wide ? (r.bs == EPC_BY_LOWER) : r.a[0];
        us1 = !(r.wide && r.sch && r.bs != EPC_BY_UPPER);
        us2 = r.sch ? us1 : !(r.wide && r.wr && r.bs != EPC_BY_LOWER);
        ls = !(r.wr && !(r.wide && !r.sch && r.bs == EPC_BY_UPPER));
        wait_ready();
        acc_space = r.sp;
        acc_write = r.wr;
        acc_wide = r.wide;
        acc_bsel = r.bs;
        acc_byte_sel_scheme = r.sch;
        acc_addr = r.a;
        acc_wdata = r.d;
        acc_start = 1'b1;
        step();
        acc_start = 1'b0;
        if (r.sp != EPC_SP_MUX) begin
            check({cs_n, muxed_bus_lines_oe_n, read_strobe_n, upper_store_strobe_n,
                lower_store_strobe_n}, {8'hff, 16'hffff, 3'h7});
            check({ras_n, column_strobe_upper_n, column_strobe_lower_n,
                parity_line_upper_oe_n, parity_line_lower_oe_n, parity_line_upper_out,
                parity_line_lower_out}, 7'h7c);
            step();
            check({acc_done, acc_ready}, 2'h3);
        end else begin
            check({cs_n, address_hold_strobe, addr_out}, {8'hbf, 1'b1, r.a[21:1]});
            check({muxed_bus_lines_oe_n, muxed_bus_lines_out & ~a1}, {a1, r.a[15:0] & ~a1});
            check({a0_high_byte_select, upper_store_strobe_n, lower_store_strobe_n,
                read_strobe_n}, {h, us1, 2'h3});
            repeat (2) begin
                step();
                check({cs_n, address_hold_strobe, read_strobe_n, upper_store_strobe_n,
                    lower_store_strobe_n, a0_high_byte_select},
                    {8'hbf, 1'b0, r.wr, us2, ls, h});
                check(muxed_bus_lines_oe_n, r.wr ? a1 : r.wide ? m : 16'hffff);
            end
            step();
            check({acc_done, acc_ready, cs_n, muxed_bus_lines_oe_n}, {2'h3, 8'hff, 16'hffff});
            check(r.wr ? wr_seen & m : acc_rdata & m, r.wr ? r.d & m : ~r.a[15:0] & m);
            check(addr_seen, r.a[15:0]);
        end
    endtask

    initial begin
        // reset-time pin function and quiet outputs
        repeat (6) @(posedge core_clk);
        #1;
        check({mux_pin_func, acc_ready, cs_n, gen_pin_oe_n}, {2'h0, 8'hff, 8'hff});
        sys_rst = 1'b0;
        step();
        check(mux_pin_func, 1'b1);
        foreach (rows[i]) run(rows[i]);
        // general pins driving, pull-up enabled
        gen_core_dir = 8'hff;
        gen_core_out = 8'ha5;
        gen_pin_in = 8'h3c;
        wait_pullup_enable = 1'b1;
        repeat (2) step();
        check({gen_pin_out, gen_pin_oe_n, gen_core_in, wait_pullup_on}, 25'h14a0079);
        // standby holding, then floating; an access tried meanwhile is refused
        for (int f = 0; f < 2; f++) begin
            standby_output_float = f[0];
            standby_req = 1'b1;
            repeat (3) step();
            gen_core_out = 8'h5a;
            gen_pin_in = 8'hc3;
            acc_space = EPC_SP_MUX;
            acc_start = 1'b1;
            repeat (3) step();
            check(gen_pin_oe_n, f[0] ? 8'hff : 8'h00);
            if (f == 0) check(gen_pin_out, 8'ha5);
            check({gen_core_in, gen_in_buf_en, bus_ctrl_oe_n, wait_pullup_on, acc_ready, cs_n},
                {8'h3c, 4'h4, 8'hff});
            acc_start = 1'b0;
            standby_req = 1'b0;
            gen_core_out = 8'ha5;
            gen_pin_in = 8'h3c;
            repeat (3) step();
            check({acc_done, cs_n, gen_in_buf_en, wait_pullup_on}, {1'b0, 8'hff, 2'h3});
        end
        wait_pullup_enable = 1'b0;
        repeat (2) step();
        check(wait_pullup_on, 1'b0);
        // reset in mid-access, then a normal access again
        acc_start = 1'b1;
        step();
        acc_start = 1'b0;
        sys_rst = 1'b1;
        step();
        check({cs_n, address_hold_strobe, mux_pin_func, muxed_bus_lines_oe_n},
            {8'hff, 2'h0, 16'hffff});
        sys_rst = 1'b0;
        run(rows[10]);
        results();
    end
endmodule

bind epc_pin_ctrl epc_pin_ctrl_properties u_props (.*);

`default_nettype wire
